/* File: hw/pci_cfg_regs.svh */
// Offsets, field positions and reset values of the configuration command/status bank
`ifndef PCI_CFG_REGS_SVH
`define PCI_CFG_REGS_SVH
// ----------------------------------------------------------------------------
// Dword indices of the configuration header
// ----------------------------------------------------------------------------
`define CFG_IDENT_DW      6'h00
`define CFG_CMDSTS_DW     6'h01
// ----------------------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------------------
`define CMD_IO_BIT        0
`define CMD_MEM_BIT       1
`define CMD_MASTER_BIT    2
`define CMD_INVAL_BIT     4
`define CMD_PARITY_BIT    6
`define CMD_SYSERR_BIT    8
`define CMD_B2B_BIT       9
`define CMD_WR_MASK       16'h0357
`define CMD_RESET         16'h0000
// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define STS_PARITY_BIT    15
`define STS_SIGSERR_BIT   14
`define STS_MABORT_BIT    13
`define STS_TABORT_BIT    12
`define STS_MASTER_DATA_PARITY_FLAG_BIT  8
`define STS_STICKY_MASK   16'hf100
`define STS_FIXED         16'h0290
`define STS_RESET         16'h0000
`define DEVSEL_DELAY      2
`endif

/* File: hw/pci_cfg_pkg.sv */
// Types and shared helpers of the configuration command/status bank
package pci_cfg_pkg;
  // --------------------------------------------------------------------------
  // Target select sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_IDLE,
    SEL_WAIT,
    SEL_DRIVE
  } select_state_e;

  // Merge a 16-bit write into an old value, one byte lane per enable bit
  function automatic logic [15:0] merge_lanes(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic [1:0]  be);
    logic [15:0] res;
    res[7:0]  = be[0] ? new_v[7:0]  : old_v[7:0];
    res[15:8] = be[1] ? new_v[15:8] : old_v[15:8];
    return res;
  endfunction : merge_lanes
endpackage : pci_cfg_pkg

/* File: hw/cfg_write_if.sv */
// Write strobes, lanes and data handed from the decoder to the register modules
interface cfg_write_if;
  logic        cmd_stb;
  logic        sts_stb;
  logic [3:0]  be;   // Lanes 1-0 command, lanes 3-2 status
  logic [31:0] data; // Full dword, so a write to both words keeps each half
  modport src  (output cmd_stb, output sts_stb, output be, output data);
  modport sink (input cmd_stb, input sts_stb, input be, input data);
endinterface : cfg_write_if

/* File: hw/cmd_register.sv */
// Command register with byte-lane writes and fixed-zero bits
`include "pci_cfg_regs.svh"
module cmd_register (
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  cfg_write_if.sink        wr_if,
  output logic [15:0]      command_o
);
  logic [15:0] command;
  logic [15:0] next_command;

  // Only writable bits survive the merge; the rest stay zero
  assign next_command = pci_cfg_pkg::merge_lanes(command, wr_if.data[15:0], wr_if.be[1:0])
                        & `CMD_WR_MASK;
  assign command_o    = command;

  // Only the hardware reset clears; soft reset and halt never reach here
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      command <= `CMD_RESET;
    end else if (wr_if.cmd_stb) begin
      command <= next_command;
    end
  end

  a_cmd_fixed_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (command & ~`CMD_WR_MASK) == 16'h0000)
    else $error("command reserved bit set");
endmodule : cmd_register

/* File: hw/status_flags.sv */
// Sticky write-one-to-clear status flags plus constant capability fields
`include "pci_cfg_regs.svh"
module status_flags (
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  cfg_write_if.sink        wr_if,
  input  wire logic [15:0] set_bits_i,
  output logic [15:0]      status_o
);
  logic [15:0] flags;
  logic [15:0] clear_bits;
  logic [15:0] next_flags;

  // Ones written on enabled lanes clear; a set in the same cycle wins
  assign clear_bits = wr_if.sts_stb ?
                      pci_cfg_pkg::merge_lanes(16'h0000, wr_if.data[31:16], wr_if.be[3:2]) :
                      16'h0000;
  assign next_flags = ((flags & ~clear_bits) | set_bits_i) & `STS_STICKY_MASK;
  assign status_o   = flags | `STS_FIXED;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      flags <= `STS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  a_set_beats_clear: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (set_bits_i[`STS_PARITY_BIT] && wr_if.sts_stb) |=> flags[`STS_PARITY_BIT])
    else $error("set lost against clear");
endmodule : status_flags

/* File: hw/pci_config_command_status.sv */
// Configuration identity, command and status words with bus-side permission outputs
// Operation
// - Offset 0 reads a 16-bit maker word mirrored from a loader-writable shadow.
// - Offset 2 reads a fixed 16-bit product word; writes do nothing.
// - With command zero, claim and start nothing except configuration cycles.
// - Command bits 15-10, 7, 5, 3 read zero; special cycles ignored.
// - Fast back-to-back mastering allowed only while its enable bit is one.
// - System error pin fires on address parity only with both enables set.
// - Parity response off only flags; on, drive parity pin and master flag.
// - Use write-and-invalidate only when its enable is set, else plain write.
// - Memory and I/O claims gated by their enables; ROM needs both enables.
// - Writable command bits clear on hardware reset only.
// - Status bit 15 sets on any detected parity error, regardless of enables.
// - Status flags sticky, cleared by writing one, cleared by hardware reset.
// - Status bit 14 sets on address parity error with both enables set.
// - Status bit 13 sets when our transaction ends by master abort.
// - Status bit 12 sets when a target aborts our transaction.
// - Status bit 11 reads zero; never end a target access with abort.
// - Select timing reads medium; select asserted two clocks after frame.
// - Status bit 8 sets on master data parity error with parity response on.
// - Status bit 7 reads one; bits 6-5 and 3-0 read zero.
// - Capability list flag reads one and ignores writes.
`include "pci_cfg_regs.svh"
module pci_config_command_status #(
  parameter logic [15:0] MAKER_IDENT_RESET = 16'h5a5a, // Arbitrary value
  parameter logic [15:0] PRODUCT_IDENT     = 16'h3c3c  // Arbitrary value
) (
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        cfg_rd_i,
  input  wire logic        cfg_wr_i,
  input  wire logic [5:0]  cfg_addr_i,
  input  wire logic [3:0]  cfg_be_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic [31:0]      cfg_rdata_o,
  output logic             cfg_rvalid_o,
  input  wire logic        shadow_wr_i,
  input  wire logic [15:0] shadow_data_i,
  input  wire logic        addr_parity_err_i,
  input  wire logic        slave_wr_parity_err_i,
  input  wire logic        master_rd_parity_err_i,
  input  wire logic        target_perr_seen_i,
  input  wire logic        master_active_i,
  input  wire logic        master_abort_i,
  input  wire logic        target_abort_i,
  input  wire logic        frame_start_i,
  input  wire logic        transaction_end_i,
  input  wire logic        special_cycle_i,
  input  wire logic        cfg_hit_i,
  input  wire logic        mem_hit_i,
  input  wire logic        io_hit_i,
  input  wire logic        rom_hit_i,
  input  wire logic        expansion_memory_enable_i,
  output logic             master_enable_o,
  output logic             back_to_back_enable_o,
  output logic             write_invalidate_enable_o,
  output logic             memory_decode_enable_o,
  output logic             io_decode_enable_o,
  output logic             serr_drive_o,
  output logic             perr_drive_o,
  output logic             devsel_o
);
  // --------------------------------------------------------------------------
  // Register access decode
  // --------------------------------------------------------------------------
  cfg_write_if wr_bus ();

  logic [15:0] maker_ident_shadow;
  logic [15:0] bus_command;
  logic [15:0] bus_status;
  logic [15:0] status_set;
  logic [31:0] next_rdata;
  logic        sel_ident;
  logic        sel_cmdsts;

  assign sel_ident  = (cfg_addr_i == `CFG_IDENT_DW);
  assign sel_cmdsts = (cfg_addr_i == `CFG_CMDSTS_DW);

  // Identity dword accepts no writes at all; only the command dword decodes
  assign wr_bus.cmd_stb = cfg_wr_i && sel_cmdsts && (cfg_be_i[1:0] != 2'b00);
  assign wr_bus.sts_stb = cfg_wr_i && sel_cmdsts && (cfg_be_i[3:2] != 2'b00);
  // Whole dword passed on; each register picks its own lanes
  assign wr_bus.be      = cfg_be_i;
  assign wr_bus.data    = cfg_wdata_i;

  // A write that touches both words reaches both modules in the same cycle
  cmd_register u_cmd (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .wr_if     (wr_bus),
    .command_o (bus_command)
  );

  status_flags u_sts (
    .ref_clk_i  (ref_clk_i),
    .sys_rst_i  (sys_rst_i),
    .wr_if      (wr_bus),
    .set_bits_i (status_set),
    .status_o   (bus_status)
  );

  // Unmapped dwords read zero
  assign next_rdata = sel_ident  ? {PRODUCT_IDENT, maker_ident_shadow} :
                      sel_cmdsts ? {bus_status, bus_command} : 32'h0000_0000;

  // --------------------------------------------------------------------------
  // Maker identity shadow
  // --------------------------------------------------------------------------
  // Loader overwrite only; host configuration writes cannot reach it
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      maker_ident_shadow <= MAKER_IDENT_RESET;
    end else if (shadow_wr_i) begin
      maker_ident_shadow <= shadow_data_i;
    end
  end

  // Read data registered; one-cycle valid pulse
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cfg_rdata_o  <= 32'h0000_0000;
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rdata_o  <= cfg_rd_i ? next_rdata : cfg_rdata_o;
      cfg_rvalid_o <= cfg_rd_i;
    end
  end

  // --------------------------------------------------------------------------
  // Error detection and reporting
  // --------------------------------------------------------------------------
  logic parity_en;
  logic syserr_en;
  logic any_parity;
  logic master_data_err;

  assign parity_en       = bus_command[`CMD_PARITY_BIT];
  assign syserr_en       = bus_command[`CMD_SYSERR_BIT];
  assign any_parity      = addr_parity_err_i | slave_wr_parity_err_i |
                           master_rd_parity_err_i | target_perr_seen_i;
  assign master_data_err = master_active_i && parity_en &&
                           (master_rd_parity_err_i || target_perr_seen_i);

  // Set sources for the sticky flags
  always_comb begin
    status_set                    = 16'h0000;
    status_set[`STS_PARITY_BIT]   = any_parity;
    status_set[`STS_SIGSERR_BIT]  = addr_parity_err_i && syserr_en && parity_en;
    status_set[`STS_MABORT_BIT]   = master_abort_i;
    status_set[`STS_TABORT_BIT]   = target_abort_i;
    status_set[`STS_MASTER_DATA_PARITY_FLAG_BIT] = master_data_err;
  end

  // Pin drive requests are one-cycle pulses to the bus engine
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      serr_drive_o <= 1'b0;
      perr_drive_o <= 1'b0;
    end else begin
      serr_drive_o <= addr_parity_err_i && syserr_en && parity_en;
      perr_drive_o <= parity_en && (slave_wr_parity_err_i || master_rd_parity_err_i);
    end
  end

  // --------------------------------------------------------------------------
  // Master and decode permissions
  // --------------------------------------------------------------------------
  // Registered copies keep every output on a flop, at one cycle of lag
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      master_enable_o           <= 1'b0;
      back_to_back_enable_o     <= 1'b0;
      write_invalidate_enable_o <= 1'b0;
      memory_decode_enable_o    <= 1'b0;
      io_decode_enable_o        <= 1'b0;
    end else begin
      master_enable_o           <= bus_command[`CMD_MASTER_BIT];
      back_to_back_enable_o     <= bus_command[`CMD_B2B_BIT];
      write_invalidate_enable_o <= bus_command[`CMD_INVAL_BIT];
      memory_decode_enable_o    <= bus_command[`CMD_MEM_BIT];
      io_decode_enable_o        <= bus_command[`CMD_IO_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Target claim and select timing
  // --------------------------------------------------------------------------
  pci_cfg_pkg::select_state_e sel_state;
  pci_cfg_pkg::select_state_e next_sel_state;
  logic                       claim;

  // Special cycles are never claimed; ROM needs both enables
  assign claim = !special_cycle_i && (cfg_hit_i ||
                 (mem_hit_i && bus_command[`CMD_MEM_BIT]) ||
                 (io_hit_i && bus_command[`CMD_IO_BIT]) ||
                 (rom_hit_i && expansion_memory_enable_i &&
                  bus_command[`CMD_MEM_BIT]));

  // Medium timing: one wait state between frame and select
  always_comb begin
    case (sel_state)
      pci_cfg_pkg::SEL_IDLE:
        next_sel_state = (frame_start_i && claim) ? pci_cfg_pkg::SEL_WAIT
                                                  : pci_cfg_pkg::SEL_IDLE;
      pci_cfg_pkg::SEL_WAIT:
        next_sel_state = pci_cfg_pkg::SEL_DRIVE;
      pci_cfg_pkg::SEL_DRIVE:
        next_sel_state = transaction_end_i ? pci_cfg_pkg::SEL_IDLE
                                           : pci_cfg_pkg::SEL_DRIVE;
      default:
        next_sel_state = pci_cfg_pkg::SEL_IDLE;
    endcase
  end

  // There is no abort path: a claimed access always runs to its end
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sel_state <= pci_cfg_pkg::SEL_IDLE;
      devsel_o  <= 1'b0;
    end else begin
      sel_state <= next_sel_state;
      devsel_o  <= (next_sel_state == pci_cfg_pkg::SEL_DRIVE);
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_serr_gated: assert property ((addr_parity_err_i && !(syserr_en && parity_en))
    |=> !serr_drive_o)
    else $error("system error driven while disabled");
  a_serr_fires: assert property ((addr_parity_err_i && syserr_en && parity_en)
    |=> serr_drive_o && bus_status[`STS_SIGSERR_BIT])
    else $error("system error not reported");
  a_parity_flag: assert property (any_parity |=> bus_status[`STS_PARITY_BIT])
    else $error("parity flag not set");
  a_abort_flags: assert property ((master_abort_i || target_abort_i) |=>
    (bus_status[`STS_MABORT_BIT] || !$past(master_abort_i)) &&
    (bus_status[`STS_TABORT_BIT] || !$past(target_abort_i)))
    else $error("abort flag not set");
  a_master_data_parity_flag_cause: assert property ($rose(bus_status[`STS_MASTER_DATA_PARITY_FLAG_BIT]) |->
    $past(master_active_i && parity_en))
    else $error("master data parity flag without cause");
  a_sticky_hold: assert property ((bus_status[`STS_MABORT_BIT] && !wr_bus.sts_stb)
    |=> bus_status[`STS_MABORT_BIT])
    else $error("sticky flag dropped");
  a_fixed_status: assert property (((bus_status ^ `STS_FIXED) & ~`STS_STICKY_MASK)
    == 16'h0000)
    else $error("fixed status field changed");
  a_devsel_timing: assert property ((sel_state == pci_cfg_pkg::SEL_IDLE &&
    frame_start_i && claim) |-> !devsel_o ##1 !devsel_o ##1 devsel_o)
    else $error("select not two clocks after frame");
  a_idle_no_claim: assert property ((sel_state == pci_cfg_pkg::SEL_IDLE &&
    frame_start_i && bus_command == 16'h0000 && !cfg_hit_i) |-> ##2 !devsel_o)
    else $error("claimed while disconnected");
  a_product_read: assert property ((cfg_rd_i && sel_ident) |=>
    cfg_rvalid_o && cfg_rdata_o[31:16] == PRODUCT_IDENT)
    else $error("product word wrong");

  c_claim_seen:  cover property (frame_start_i && claim ##2 devsel_o);
  c_serr_report: cover property (addr_parity_err_i && syserr_en && parity_en);
  c_flag_clear:  cover property (bus_status[`STS_PARITY_BIT] ##1
                                 !bus_status[`STS_PARITY_BIT]);
  c_master_on:   cover property ($rose(master_enable_o));
endmodule : pci_config_command_status

/* File: tb/bus_agent.sv */
// Far-side bus engine model: frames with address hits and end pulses
module bus_agent (
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       start_i,
  input  wire logic [2:0] kind_i,
  input  wire logic [2:0] hold_i,
  output logic            frame_start_o,
  output logic [3:0]      hit_o,
  output logic            special_o,
  output logic            transaction_end_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------------------------------------------------
  // Frame sequencer
  // --------------------------------------------------------------------------
  logic [2:0] cnt;
  // Hits mean nothing outside the frame start, so they churn there on purpose
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      frame_start_o     <= 1'b0;
      hit_o             <= 4'h0;
      special_o         <= 1'b0;
      transaction_end_o <= 1'b0;
      cnt               <= 3'h0;
    end else begin
      frame_start_o     <= start_i;
      transaction_end_o <= (cnt == 3'h1);
      cnt               <= start_i ? hold_i : ((cnt != 3'h0) ? cnt - 3'h1 : 3'h0);
      hit_o             <= start_i ? (4'h1 << kind_i[1:0]) : ~hit_o;
      special_o         <= start_i ? kind_i[2] : ~special_o;
    end
  end
endmodule : bus_agent

/* File: tb/testbench.sv */
// Self-checking bench of the configuration command/status bank
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  typedef struct {logic [5:0] a; logic [3:0] b; logic [31:0] d; logic [31:0] e;} row_s;
  logic        ref_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        rd = 1'b0, wr = 1'b0, shadow_wr = 1'b0, master_active = 1'b0;
  logic        rom_en = 1'b0, start = 1'b0;
  logic [5:0]  addr = 6'h00, evt = 6'h00;
  logic [3:0]  be = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [15:0] shadow_data = 16'h0;
  logic [2:0]  kind = 3'h0;
  logic [31:0] rdata;
  logic [3:0]  hit;
  logic        rvalid, frame_start, special, tr_end, serr, perr, devsel;
  logic        en_master, en_b2b, en_winv, en_mem, en_io;
  int          n_mismatch = 0;
  int          n_checks = 0;
  logic [2:0]  fk [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
  row_s rows [6] = '{'{6'h01, 4'h3, 32'hffffffff, 32'h02900357},
                     '{6'h01, 4'h1, 32'h00000000, 32'h02900300},
                     '{6'h01, 4'hf, 32'h00000000, 32'h02900000},
                     '{6'h00, 4'hf, 32'hffffffff, 32'h3c3c5a5a},
                     '{6'h02, 4'hf, 32'hffffffff, 32'h00000000},
                     '{6'h01, 4'h3, 32'h00000147, 32'h02900147}};
  always #2 ref_clk_i = ~ref_clk_i;
  // --------------------------------------------------------------------------
  // Design and far side
  // --------------------------------------------------------------------------
  pci_config_command_status u_pci_config_command_status (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .cfg_rd_i(rd), .cfg_wr_i(wr),
    .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata),
    .cfg_rvalid_o(rvalid), .shadow_wr_i(shadow_wr), .shadow_data_i(shadow_data),
    .addr_parity_err_i(evt[0]), .slave_wr_parity_err_i(evt[1]),
    .master_rd_parity_err_i(evt[2]), .target_perr_seen_i(evt[3]),
    .master_active_i(master_active), .master_abort_i(evt[4]), .target_abort_i(evt[5]),
    .frame_start_i(frame_start), .transaction_end_i(tr_end), .special_cycle_i(special),
    .cfg_hit_i(hit[0]), .mem_hit_i(hit[1]), .io_hit_i(hit[2]), .rom_hit_i(hit[3]),
    .expansion_memory_enable_i(rom_en), .master_enable_o(en_master),
    .back_to_back_enable_o(en_b2b), .write_invalidate_enable_o(en_winv),
    .memory_decode_enable_o(en_mem), .io_decode_enable_o(en_io),
    .serr_drive_o(serr), .perr_drive_o(perr), .devsel_o(devsel));
  bus_agent u_bus_agent (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .start_i(start), .kind_i(kind),
    .hold_i(3'h2 + kind), .frame_start_o(frame_start), .hit_o(hit), .special_o(special),
    .transaction_end_o(tr_end));
  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic cfg_write(input logic [5:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge ref_clk_i);
    wr <= 1'b1;
    addr <= a;
    be <= b;
    wdata <= d;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask : cfg_write
  // Read answers exactly one cycle after the request edge
  task automatic cfg_check(input logic [5:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask : cfg_check
  task automatic pulse(input logic [5:0] v, input logic es, input logic ep);
    @(posedge ref_clk_i);
    evt <= v;
    @(posedge ref_clk_i);
    evt <= 6'h00;
    #1;
    `CHK("serr_drive", es, serr)
    `CHK("perr_drive", ep, perr)
  endtask : pulse
  // Select must be low one cycle after frame start and at e the cycle after
  task automatic frame(input logic [2:0] k, input logic e);
    @(posedge ref_clk_i);
    start <= 1'b1;
    kind <= k;
    @(posedge ref_clk_i);
    start <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    `CHK("devsel early", 1'b0, devsel)
    @(posedge ref_clk_i);
    #1;
    `CHK("devsel", e, devsel)
    repeat (10) @(posedge ref_clk_i);
    #1;
    `CHK("devsel end", 1'b0, devsel)
  endtask : frame
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  // --------------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------------
  // Watchdog: a hang counts against the run instead of stalling it
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_mismatch++;
    results();
  end
  initial begin
    repeat (3) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    cfg_check(6'h01, 32'h02900000);
    `CHK("enables", 5'h00, {en_master, en_b2b, en_winv, en_mem, en_io})
    $display("test reset done");
    // Host order: all writable bits set, then cleared by lane, then master, decode and error enables last
    foreach (rows[i]) begin
      cfg_write(rows[i].a, rows[i].b, rows[i].d);
      cfg_check(rows[i].a, rows[i].e);
    end
    @(posedge ref_clk_i);
    #1;
    `CHK("enables", 5'b10011, {en_master, en_b2b, en_winv, en_mem, en_io})
    $display("test rows done");
    @(posedge ref_clk_i);
    rom_en <= 1'b1;
    foreach (fk[i]) frame(fk[i], fk[i] != 3'h5);
    @(posedge ref_clk_i);
    rom_en <= 1'b0;
    frame(3'h3, 1'b0);
    cfg_write(6'h01, 4'h3, 32'h0);
    foreach (fk[i]) frame(fk[i], fk[i] == 3'h0);
    $display("test select done");
    cfg_write(6'h01, 4'h3, 32'h0147);
    pulse(6'h01, 1'b1, 1'b0);
    pulse(6'h02, 1'b0, 1'b1);
    @(posedge ref_clk_i);
    master_active <= 1'b1;
    pulse(6'h0c, 1'b0, 1'b1);
    pulse(6'h30, 1'b0, 1'b0);
    cfg_check(6'h01, 32'hf3900147);
    cfg_write(6'h01, 4'hc, 32'h0);
    cfg_check(6'h01, 32'hf3900147);
    cfg_write(6'h01, 4'hc, 32'ha0000000);
    cfg_check(6'h01, 32'h53900147);
    cfg_write(6'h01, 4'hf, 32'hffff0104);
    cfg_check(6'h01, 32'h02900104);
    pulse(6'h01, 1'b0, 1'b0);
    pulse(6'h0c, 1'b0, 1'b0);
    cfg_check(6'h01, 32'h82900104);
    // Parity event and its write-one clear in the same cycle: the set must win
    @(posedge ref_clk_i);
    evt <= 6'h01;
    wr <= 1'b1;
    addr <= 6'h01;
    be <= 4'hc;
    wdata <= 32'h8000_0000;
    @(posedge ref_clk_i);
    evt <= 6'h00;
    wr <= 1'b0;
    cfg_check(6'h01, 32'h82900104);
    $display("test status done");
    cfg_write(6'h01, 4'h3, 32'h0350);
    @(posedge ref_clk_i);
    #1;
    `CHK("enables", 5'b01100, {en_master, en_b2b, en_winv, en_mem, en_io})
    @(posedge ref_clk_i);
    shadow_wr <= 1'b1;
    shadow_data <= 16'h1234;
    @(posedge ref_clk_i);
    shadow_wr <= 1'b0;
    cfg_check(6'h00, 32'h3c3c1234);
    $display("test shadow done");
    // A second hardware reset in mid-run must return everything to its reset value again
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    cfg_check(6'h01, 32'h02900000);
    cfg_check(6'h00, 32'h3c3c5a5a);
    $display("test rereset done");
    results();
  end
endmodule : testbench
